// file: core/plc_top.v
// Control registers for display PLL A and B with divider application to the analog core.
// Assumes vertical blank inputs are one-cycle pulses and divisor-set words come from their own registers.
// How it works
// - Most fields are held and applied at the next transcoder vertical blank.
// - Writes are dropped while the panel sequencer has a panel on this transcoder.
// - Bit 31 runs the oscillator core; clear stops it and the pixel clock.
// - Bits 27:26 pick non-LVDS (01, default) or LVDS (10); others reserved.
// - Second divider code 00 divides by 14 in LVDS mode, by 10 in non-LVDS mode.
// - Code 01 divides by 7 dual LVDS, 5 fast DAC/HDMI; others reserved.
// - First divider byte write with core disabled commits M, N, P values.
// - Writes to the idle divisor set leave the active set untouched.
// - First divider bytes take effect at once, not at vertical blank.
// - Reference select bits 15:13 bypass double buffering; 000, 001, 011 valid.
// - Bits 11:9 hold multiplier minus one, 1x to 4x.
// - Divisor fields are two less than actual; two is added.
// - Dot clock is reference times M over N over first and second divide.
`timescale 1ns/1ps
`default_nettype none
`include "plc_map.vh"

module plc_top (
    input  wire                   clock,
    input  wire                   srst,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    input  wire [`PLC_ADDR_W-1:0] reg_addr,
    input  wire [3:0]             reg_be,
    input  wire [31:0]            reg_wdata,
    output reg  [31:0]            reg_rdata,
    output reg                    reg_rvalid,
    output reg                    reg_wr_blocked,
    input  wire                   vblank_a,
    input  wire                   vblank_b,
    input  wire                   panel_attached_a,
    input  wire                   panel_attached_b,
    input  wire                   set_in_use_a,
    input  wire                   set_in_use_b,
    input  wire                   dual_channel_a,
    input  wire                   dual_channel_b,
    input  wire                   display_port_a,
    input  wire                   display_port_b,
    input  wire [31:0]            divisor_set_0_a,
    input  wire [31:0]            divisor_set_1_a,
    input  wire [31:0]            divisor_set_0_b,
    input  wire [31:0]            divisor_set_1_b,
    output reg                    oscillator_core_en_a,
    output reg                    oscillator_core_en_b,
    output reg                    pixel_clock_run_a,
    output reg                    pixel_clock_run_b,
    output reg                    hsio_clock_en_a,
    output reg                    hsio_clock_en_b,
    output reg                    lvds_mode_a,
    output reg                    lvds_mode_b,
    output reg  [2:0]             ref_select_a,
    output reg  [2:0]             ref_select_b,
    output reg  [2:0]             multiplier_factor_a,
    output reg  [2:0]             multiplier_factor_b,
    output reg                    config_error_a,
    output reg                    config_error_b,
    output reg                    divisor_commit_a,
    output reg                    divisor_commit_b,
    output wire [8:0]             m_total_a,
    output wire [8:0]             m_total_b,
    output wire [6:0]             n_total_a,
    output wire [6:0]             n_total_b,
    output wire [7:0]             p_total_a,
    output wire [7:0]             p_total_b
);

    wire        hit_a = (reg_addr == `PLC_PLL_A_CONTROL);
    wire        hit_b = (reg_addr == `PLC_PLL_B_CONTROL);
    wire        wr_a  = reg_wr & hit_a & ~panel_attached_a;
    wire        wr_b  = reg_wr & hit_b & ~panel_attached_b;
    wire [31:0] shadow_a;
    wire [31:0] shadow_b;
    wire [31:0] active_a;
    wire [31:0] active_b;
    wire        p1_written_a;
    wire        p1_written_b;

    reg  [31:0] applied_div_a;
    reg  [31:0] applied_div_b;
    reg  [3:0]  p1_value_a;
    reg  [3:0]  p1_value_b;
    reg  [3:0]  p2_value_a;
    reg  [3:0]  p2_value_b;
    reg         p1_bad_a;
    reg         p1_bad_b;

    // First divider one-hot decode; zero flags a reserved pattern
    function [3:0] p1_decode;
        input [7:0] onehot;
        begin
            case (onehot)
                8'h01:   p1_decode = 4'h1;
                8'h02:   p1_decode = 4'h2;
                8'h04:   p1_decode = 4'h3;
                8'h08:   p1_decode = 4'h4;
                8'h10:   p1_decode = 4'h5;
                8'h20:   p1_decode = 4'h6;
                8'h40:   p1_decode = 4'h7;
                8'h80:   p1_decode = 4'h8;
                default: p1_decode = 4'h0;
            endcase
        end
    endfunction

    // Second divider from code, mode and link type; zero flags reserved
    function [3:0] p2_decode;
        input [1:0] code;
        input [1:0] mode;
        input       dual;
        input       dp;
        begin
            p2_decode = 4'h0;
            if (code == `PLC_P2_SLOW) begin
                if (mode == `PLC_MODE_LVDS) begin
                    p2_decode = 4'hE;
                end else if (mode == `PLC_MODE_NON_LVDS) begin
                    p2_decode = 4'hA;
                end
            end else if (code == `PLC_P2_FAST) begin
                if (mode == `PLC_MODE_LVDS && dual) begin
                    p2_decode = 4'h7;
                end else if (mode == `PLC_MODE_NON_LVDS && !dp) begin
                    p2_decode = 4'h5;
                end
            end
        end
    endfunction

    // Reference code check
    function ref_ok;
        input [2:0] sel;
        begin
            ref_ok = (sel == `PLC_REF_DISPLAY) || (sel == `PLC_REF_SUPER) || (sel == `PLC_REF_SPREAD);
        end
    endfunction

    plc_ctl_chan u_chan_a (
        .clock      (clock),
        .srst       (srst),
        .wr         (wr_a),
        .be         (reg_be),
        .wdata      (reg_wdata),
        .vblank     (vblank_a),
        .shadow     (shadow_a),
        .active     (active_a),
        .p1_written (p1_written_a)
    );

    plc_ctl_chan u_chan_b (
        .clock      (clock),
        .srst       (srst),
        .wr         (wr_b),
        .be         (reg_be),
        .wdata      (reg_wdata),
        .vblank     (vblank_b),
        .shadow     (shadow_b),
        .active     (active_b),
        .p1_written (p1_written_b)
    );

    // Register read port and protection report
    always @(posedge clock) begin
        if (srst) begin
            reg_rdata      <= 32'h00000000;
            reg_rvalid     <= 1'b0;
            reg_wr_blocked <= 1'b0;
        end else begin
            reg_rvalid     <= reg_rd;
            reg_wr_blocked <= reg_wr & ((hit_a & panel_attached_a) | (hit_b & panel_attached_b));
            if (!reg_rd) begin
                reg_rdata <= 32'h00000000;
            end else if (hit_a) begin
                reg_rdata <= shadow_a;
            end else if (hit_b) begin
                reg_rdata <= shadow_b;
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end
    end

    // Divisor application: set in use only, at commit with core off or at vertical blank with core on
    always @(posedge clock) begin
        if (srst) begin
            applied_div_a    <= 32'h00000000;
            applied_div_b    <= 32'h00000000;
            divisor_commit_a <= 1'b0;
            divisor_commit_b <= 1'b0;
        end else begin
            divisor_commit_a <= p1_written_a & ~active_a[`PLC_VCO_EN];
            divisor_commit_b <= p1_written_b & ~active_b[`PLC_VCO_EN];
            if ((p1_written_a & ~active_a[`PLC_VCO_EN]) | (vblank_a & active_a[`PLC_VCO_EN])) begin
                applied_div_a <= set_in_use_a ? divisor_set_1_a : divisor_set_0_a;
            end
            if ((p1_written_b & ~active_b[`PLC_VCO_EN]) | (vblank_b & active_b[`PLC_VCO_EN])) begin
                applied_div_b <= set_in_use_b ? divisor_set_1_b : divisor_set_0_b;
            end
        end
    end

    // Post divider values from the live register
    always @(posedge clock) begin
        if (srst) begin
            p1_value_a <= 4'h8;
            p1_value_b <= 4'h8;
            p2_value_a <= 4'hA;
            p2_value_b <= 4'hA;
            p1_bad_a   <= 1'b0;
            p1_bad_b   <= 1'b0;
        end else begin
            p1_value_a <= set_in_use_a ? p1_decode(active_a[`PLC_P1S1_HI:`PLC_P1S1_LO])
                                       : p1_decode(active_a[`PLC_P1S0_HI:`PLC_P1S0_LO]);
            p1_value_b <= set_in_use_b ? p1_decode(active_b[`PLC_P1S1_HI:`PLC_P1S1_LO])
                                       : p1_decode(active_b[`PLC_P1S0_HI:`PLC_P1S0_LO]);
            p1_bad_a   <= (p1_decode(active_a[`PLC_P1S0_HI:`PLC_P1S0_LO]) == 4'h0)
                        | (p1_decode(active_a[`PLC_P1S1_HI:`PLC_P1S1_LO]) == 4'h0);
            p1_bad_b   <= (p1_decode(active_b[`PLC_P1S0_HI:`PLC_P1S0_LO]) == 4'h0)
                        | (p1_decode(active_b[`PLC_P1S1_HI:`PLC_P1S1_LO]) == 4'h0);
            p2_value_a <= p2_decode(active_a[`PLC_P2_HI:`PLC_P2_LO], active_a[`PLC_MODE_HI:`PLC_MODE_LO],
                                    dual_channel_a, display_port_a);
            p2_value_b <= p2_decode(active_b[`PLC_P2_HI:`PLC_P2_LO], active_b[`PLC_MODE_HI:`PLC_MODE_LO],
                                    dual_channel_b, display_port_b);
        end
    end

    // Analog core controls
    always @(posedge clock) begin
        if (srst) begin
            oscillator_core_en_a <= 1'b0;
            oscillator_core_en_b <= 1'b0;
            pixel_clock_run_a    <= 1'b0;
            pixel_clock_run_b    <= 1'b0;
            hsio_clock_en_a      <= 1'b0;
            hsio_clock_en_b      <= 1'b0;
            lvds_mode_a          <= 1'b0;
            lvds_mode_b          <= 1'b0;
            ref_select_a         <= `PLC_REF_DISPLAY;
            ref_select_b         <= `PLC_REF_DISPLAY;
            multiplier_factor_a  <= 3'h1;
            multiplier_factor_b  <= 3'h1;
            config_error_a       <= 1'b0;
            config_error_b       <= 1'b0;
        end else begin
            oscillator_core_en_a <= active_a[`PLC_VCO_EN];
            oscillator_core_en_b <= active_b[`PLC_VCO_EN];
            pixel_clock_run_a    <= active_a[`PLC_VCO_EN] & (p1_value_a != 4'h0) & (p2_value_a != 4'h0);
            pixel_clock_run_b    <= active_b[`PLC_VCO_EN] & (p1_value_b != 4'h0) & (p2_value_b != 4'h0);
            hsio_clock_en_a      <= active_a[`PLC_HSIO_EN];
            hsio_clock_en_b      <= active_b[`PLC_HSIO_EN];
            lvds_mode_a          <= (active_a[`PLC_MODE_HI:`PLC_MODE_LO] == `PLC_MODE_LVDS);
            lvds_mode_b          <= (active_b[`PLC_MODE_HI:`PLC_MODE_LO] == `PLC_MODE_LVDS);
            ref_select_a         <= active_a[`PLC_REF_HI:`PLC_REF_LO];
            ref_select_b         <= active_b[`PLC_REF_HI:`PLC_REF_LO];
            multiplier_factor_a  <= {1'b0, active_a[`PLC_MULT_HI-1:`PLC_MULT_LO]} + 3'h1;
            multiplier_factor_b  <= {1'b0, active_b[`PLC_MULT_HI-1:`PLC_MULT_LO]} + 3'h1;
            config_error_a       <= (p2_value_a == 4'h0) | p1_bad_a | active_a[`PLC_MULT_HI]
                                  | ~ref_ok(active_a[`PLC_REF_HI:`PLC_REF_LO]);
            config_error_b       <= (p2_value_b == 4'h0) | p1_bad_b | active_b[`PLC_MULT_HI]
                                  | ~ref_ok(active_b[`PLC_REF_HI:`PLC_REF_LO]);
        end
    end

    plc_dot_calc u_calc_a (
        .clock    (clock),
        .srst     (srst),
        .n_field  (applied_div_a[`PLC_DIV_N_HI:`PLC_DIV_N_LO]),
        .m1_field (applied_div_a[`PLC_DIV_M1_HI:`PLC_DIV_M1_LO]),
        .m2_field (applied_div_a[`PLC_DIV_M2_HI:`PLC_DIV_M2_LO]),
        .p1_value (p1_value_a),
        .p2_value (p2_value_a),
        .m_total  (m_total_a),
        .n_total  (n_total_a),
        .p_total  (p_total_a)
    );

    plc_dot_calc u_calc_b (
        .clock    (clock),
        .srst     (srst),
        .n_field  (applied_div_b[`PLC_DIV_N_HI:`PLC_DIV_N_LO]),
        .m1_field (applied_div_b[`PLC_DIV_M1_HI:`PLC_DIV_M1_LO]),
        .m2_field (applied_div_b[`PLC_DIV_M2_HI:`PLC_DIV_M2_LO]),
        .p1_value (p1_value_b),
        .p2_value (p2_value_b),
        .m_total  (m_total_b),
        .n_total  (n_total_b),
        .p_total  (p_total_b)
    );

endmodule // plc_top

`default_nettype wire

// file: core/plc_map.vh
// Register offsets, field positions and reset values for the display PLL control block.
// Assumes byte addresses on the register port and 32-bit register words.
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

`define PLC_ADDR_W          20
`define PLC_PLL_A_CONTROL   20'hC6014
`define PLC_PLL_B_CONTROL   20'hC6018
`define PLC_CTL_RESET       32'h04800080
`define PLC_CTL_WMASK       32'hCFFFEEFF
`define PLC_CTL_IMMED       32'h00FFE0FF

`define PLC_VCO_EN          31
`define PLC_HSIO_EN         30
`define PLC_MODE_HI         27
`define PLC_MODE_LO         26
`define PLC_P2_HI           25
`define PLC_P2_LO           24
`define PLC_P1S0_HI         23
`define PLC_P1S0_LO         16
`define PLC_REF_HI          15
`define PLC_REF_LO          13
`define PLC_MULT_HI         11
`define PLC_MULT_LO         9
`define PLC_P1S1_HI         7
`define PLC_P1S1_LO         0

`define PLC_MODE_NON_LVDS   2'h1
`define PLC_MODE_LVDS       2'h2
`define PLC_P2_SLOW         2'h0
`define PLC_P2_FAST         2'h1
`define PLC_REF_DISPLAY     3'h0
`define PLC_REF_SUPER       3'h1
`define PLC_REF_SPREAD      3'h3

`define PLC_DIV_N_HI        21
`define PLC_DIV_N_LO        16
`define PLC_DIV_M1_HI       13
`define PLC_DIV_M1_LO       8
`define PLC_DIV_M2_HI       5
`define PLC_DIV_M2_LO       0
`define PLC_DIV_OFFSET      8'h02
`define PLC_M1_WEIGHT       8'h05

`endif

// file: core/plc_ctl_chan.v
// One PLL control register: software copy, live copy and vertical blank transfer.
// Assumes write strobes are already qualified by address and write protection.
`timescale 1ns/1ps
`default_nettype none
`include "plc_map.vh"

module plc_ctl_chan (
    input  wire        clock,
    input  wire        srst,
    input  wire        wr,
    input  wire [3:0]  be,
    input  wire [31:0] wdata,
    input  wire        vblank,
    output reg  [31:0] shadow,
    output reg  [31:0] active,
    output reg         p1_written
);

    reg  [31:0] next_shadow;
    reg  [31:0] lane_mask;
    integer     i;

    always @* begin
        for (i = 0; i < 32; i = i + 1) begin
            lane_mask[i] = be[i / 8];
        end
        next_shadow = shadow;
        if (wr) begin
            next_shadow = (shadow & ~(lane_mask & `PLC_CTL_WMASK)) | (wdata & lane_mask & `PLC_CTL_WMASK);
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            shadow     <= `PLC_CTL_RESET;
            active     <= `PLC_CTL_RESET;
            p1_written <= 1'b0;
        end else begin
            shadow     <= next_shadow;
            p1_written <= wr & (be[2] | be[0]);
            if (vblank) begin
                active <= next_shadow;
            end else begin
                active <= (active & ~`PLC_CTL_IMMED) | (next_shadow & `PLC_CTL_IMMED);
            end
        end
    end

endmodule // plc_ctl_chan

`default_nettype wire

// file: core/plc_dot_calc.v
// Divider arithmetic for one PLL: feedback, reference and post divide totals.
// Assumes fields in the two-less-than-actual divisor format.
`timescale 1ns/1ps
`default_nettype none
`include "plc_map.vh"

module plc_dot_calc (
    input  wire       clock,
    input  wire       srst,
    input  wire [5:0] n_field,
    input  wire [5:0] m1_field,
    input  wire [5:0] m2_field,
    input  wire [3:0] p1_value,
    input  wire [3:0] p2_value,
    output reg  [8:0] m_total,
    output reg  [6:0] n_total,
    output reg  [7:0] p_total
);

    wire [8:0] m1_act = {3'h0, m1_field} + {1'b0, `PLC_DIV_OFFSET};
    wire [8:0] m2_act = {3'h0, m2_field} + {1'b0, `PLC_DIV_OFFSET};
    wire [8:0] m1_x5  = (m1_act << 2) + m1_act;
    wire [7:0] div_off = `PLC_DIV_OFFSET;

    always @(posedge clock) begin
        if (srst) begin
            m_total <= 9'h000;
            n_total <= 7'h00;
            p_total <= 8'h00;
        end else begin
            m_total <= m1_x5 + m2_act;
            n_total <= {1'b0, n_field} + div_off[6:0];
            p_total <= {4'h0, p1_value} * {4'h0, p2_value};
        end
    end

endmodule // plc_dot_calc

`default_nettype wire

// file: tb/plc_top_chk.sv
// Concurrent checks on the display PLL control block ports, bound into plc_top.
// Assumes the register map header is on the include path and one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "plc_map.vh"

module plc_top_chk (
    input wire logic        clock,
    input wire logic        srst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [19:0] reg_addr,
    input wire logic [3:0]  reg_be,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        reg_wr_blocked,
    input wire logic        vblank_a,
    input wire logic        vblank_b,
    input wire logic        panel_attached_a,
    input wire logic        oscillator_core_en_a,
    input wire logic        lvds_mode_b,
    input wire logic [2:0]  ref_select_a,
    input wire logic        divisor_commit_a
);
    wire hit_a = reg_wr && (reg_addr == `PLC_PLL_A_CONTROL);

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_read_reserved: assert property (reg_rd |=> reg_rvalid && reg_rdata[29:28] == 2'h0 && !reg_rdata[12] && !reg_rdata[8])
        else $error("read answer missing or reserved bits set");
    a_write_blocked: assert property (hit_a && panel_attached_a |=> reg_wr_blocked)
        else $error("protected write not flagged");
    a_write_free: assert property (hit_a && !panel_attached_a |=> !reg_wr_blocked)
        else $error("unprotected write flagged");
    a_ref_direct: assert property (hit_a && !panel_attached_a && reg_be[1] |-> ##2 ref_select_a == $past(reg_wdata[15:13], 2))
        else $error("reference select not applied at once");
    a_vco_vblank: assert property ($changed(oscillator_core_en_a) |-> $past(vblank_a, 2))
        else $error("core enable changed away from vertical blank");
    a_lvds_vblank: assert property ($rose(lvds_mode_b) |-> $past(vblank_b, 2))
        else $error("mode changed away from vertical blank");
    a_commit_idle: assert property (hit_a && reg_be[2] && !panel_attached_a && !oscillator_core_en_a && !vblank_a
        && !$past(vblank_a) |-> ##2 divisor_commit_a)
        else $error("divisor commit missing");
    a_commit_cause: assert property (divisor_commit_a |-> $past(reg_wr, 2) && ($past(reg_be[2], 2) || $past(reg_be[0], 2)))
        else $error("divisor commit without divider byte write");

    c_blocked: cover property (reg_wr_blocked);
    c_commit: cover property (divisor_commit_a);
    c_vco_on: cover property ($rose(oscillator_core_en_a));
endmodule // plc_top_chk

bind plc_top plc_top_chk chk_u (.clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_wr_blocked(reg_wr_blocked), .vblank_a(vblank_a), .vblank_b(vblank_b), .panel_attached_a(panel_attached_a),
    .oscillator_core_en_a(oscillator_core_en_a), .lvds_mode_b(lvds_mode_b), .ref_select_a(ref_select_a),
    .divisor_commit_a(divisor_commit_a));

`default_nettype wire

// file: tb/plc_tb.sv
// Self-checking testbench for the display PLL control block.
// Assumes plc_top and the register map header are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "plc_map.vh"

module tb;
    logic        clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, vblank_a = 1'b0, vblank_b = 1'b0;
    logic        panel_attached_a = 1'b0, panel_attached_b = 1'b0, set_in_use_a = 1'b0;
    logic        dual_channel_a = 1'b0, display_port_a = 1'b0, last_blk;
    logic [19:0] reg_addr = 20'h0;
    logic [3:0]  reg_be = 4'h0;
    logic [31:0] reg_wdata = 32'h0, divisor_set_0_a = 32'h0, divisor_set_1_a = 32'h0, rd_val, reg_rdata;
    logic        reg_rvalid, reg_wr_blocked, osc_a, osc_b, pix_a, lvds_a, lvds_b, cerr_a, commit_a, hsio_a;
    logic [2:0]  ref_a, mult_a;
    logic [8:0]  m_a;
    logic [6:0]  n_a;
    logic [7:0]  p_a;
    int          error_cnt = 0, check_count = 0;

    always #2.5 clock = ~clock;

    plc_top dut_u (.clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_wr_blocked(reg_wr_blocked), .vblank_a(vblank_a), .vblank_b(vblank_b),
        .panel_attached_a(panel_attached_a), .panel_attached_b(panel_attached_b), .set_in_use_a(set_in_use_a),
        .set_in_use_b(1'b0), .dual_channel_a(dual_channel_a), .dual_channel_b(1'b0),
        .display_port_a(display_port_a), .display_port_b(1'b0), .divisor_set_0_a(divisor_set_0_a),
        .divisor_set_1_a(divisor_set_1_a), .divisor_set_0_b(32'h0), .divisor_set_1_b(32'h0),
        .oscillator_core_en_a(osc_a), .oscillator_core_en_b(osc_b), .pixel_clock_run_a(pix_a),
        .pixel_clock_run_b(), .hsio_clock_en_a(hsio_a), .hsio_clock_en_b(), .lvds_mode_a(lvds_a),
        .lvds_mode_b(lvds_b),
        .ref_select_a(ref_a), .ref_select_b(), .multiplier_factor_a(mult_a), .multiplier_factor_b(),
        .config_error_a(cerr_a), .config_error_b(), .divisor_commit_a(commit_a), .divisor_commit_b(),
        .m_total_a(m_a), .m_total_b(), .n_total_a(n_a), .n_total_b(), .p_total_a(p_a), .p_total_b());

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask

    // Write, then one idle cycle; returns in the cycle where control outputs follow
    task automatic wr(input logic [19:0] a, input logic [3:0] be, input logic [31:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_be = be;
        reg_wdata = d;
        cyc(1);
        reg_wr = 1'b0;
        last_blk = reg_wr_blocked;
        cyc(1);
    endtask

    task automatic rd(input logic [19:0] a);
        reg_rd = 1'b1;
        reg_addr = a;
        cyc(1);
        chk("rvalid", 32'(reg_rvalid), 32'h1);
        rd_val = reg_rdata;
        reg_rd = 1'b0;
        cyc(1);
    endtask

    task automatic vb(input logic on_b);
        if (on_b) vblank_b = 1'b1;
        else vblank_a = 1'b1;
        cyc(1);
        vblank_a = 1'b0;
        vblank_b = 1'b0;
        cyc(1);
    endtask

    task automatic t_reset;
        cyc(4);
        rd(`PLC_PLL_A_CONTROL);
        chk("reset_a", rd_val, 32'h04800080);
        rd(`PLC_PLL_B_CONTROL);
        chk("reset_b", rd_val, 32'h04800080);
        rd(20'hC601C);
        chk("unmapped", rd_val, 32'h0);
        chk("ref_rst", 32'(ref_a), 32'h0);
        chk("mult_rst", 32'(mult_a), 32'h1);
        chk("p_rst", 32'(p_a), 32'h50);
    endtask

    task automatic t_protect;
        panel_attached_a = 1'b1;
        wr(`PLC_PLL_A_CONTROL, 4'hF, 32'h0);
        chk("blk_a", 32'(last_blk), 32'h1);
        rd(`PLC_PLL_A_CONTROL);
        chk("kept_a", rd_val, 32'h04800080);
        panel_attached_a = 1'b0;
        panel_attached_b = 1'b1;
        wr(`PLC_PLL_A_CONTROL, 4'h1, 32'h80);
        chk("free_a", 32'(last_blk), 32'h0);
        wr(`PLC_PLL_B_CONTROL, 4'h8, 32'h08000000);
        chk("blk_b", 32'(last_blk), 32'h1);
        panel_attached_b = 1'b0;
        wr(`PLC_PLL_B_CONTROL, 4'h8, 32'h08000000);
        vb(1'b1);
        chk("lvds_b", 32'(lvds_b), 32'h1);
        chk("osc_b", 32'(osc_b), 32'h0);
        chk("lvds_a", 32'(lvds_a), 32'h0);
    endtask

    task automatic t_buffer;
        wr(`PLC_PLL_A_CONTROL, 4'hF, 32'hB8801180);
        rd(`PLC_PLL_A_CONTROL);
        chk("rsvd", rd_val, 32'h88800080);
        chk("osc_wait", 32'(osc_a), 32'h0);
        chk("lvds_wait", 32'(lvds_a), 32'h0);
        vb(1'b0);
        chk("osc_on", 32'(osc_a), 32'h1);
        chk("lvds_on", 32'(lvds_a), 32'h1);
        chk("hsio_off", 32'(hsio_a), 32'h0);
        wr(`PLC_PLL_A_CONTROL, 4'h2, 32'h00001700);
        chk("mult_wait", 32'(mult_a), 32'h1);
        vb(1'b0);
        chk("mult_on", 32'(mult_a), 32'h4);
        cyc(2);
        chk("pix_run", 32'(pix_a), 32'h1);
        chk("p_lvds", 32'(p_a), 32'h70);
        chk("osc_b_off", 32'(osc_b), 32'h0);
    endtask

    task automatic t_ref;
        logic [2:0] codes [3] = '{3'h0, 3'h1, 3'h3};
        foreach (codes[i]) begin
            wr(`PLC_PLL_A_CONTROL, 4'h2, {16'h0, codes[i], 13'h0600});
            chk("ref", 32'(ref_a), 32'(codes[i]));
        end
    endtask

    task automatic t_p2;
        dual_channel_a = 1'b1;
        wr(`PLC_PLL_A_CONTROL, 4'h8, 32'h89000000);
        vb(1'b0);
        cyc(2);
        chk("p_dual", 32'(p_a), 32'h38);
        wr(`PLC_PLL_A_CONTROL, 4'h4, 32'h00010000);
        cyc(2);
        chk("p_div1", 32'(p_a), 32'h07);
        wr(`PLC_PLL_A_CONTROL, 4'h1, 32'h00000004);
        cyc(2);
        chk("p_idle", 32'(p_a), 32'h07);
        set_in_use_a = 1'b1;
        cyc(4);
        chk("p_set1", 32'(p_a), 32'h15);
        set_in_use_a = 1'b0;
        cyc(4);
    endtask

    task automatic t_commit;
        wr(`PLC_PLL_A_CONTROL, 4'h8, 32'h04000000);
        vb(1'b0);
        cyc(2);
        chk("osc_off", 32'(osc_a), 32'h0);
        chk("pix_off", 32'(pix_a), 32'h0);
        divisor_set_0_a = 32'h00030F05;
        cyc(2);
        wr(`PLC_PLL_A_CONTROL, 4'h4, 32'h00800000);
        chk("commit", 32'(commit_a), 32'h1);
        cyc(2);
        chk("m_tot", 32'(m_a), 32'h5C);
        chk("n_tot", 32'(n_a), 32'h05);
        chk("p_tot", 32'(p_a), 32'h50);
        chk("cerr_ok", 32'(cerr_a), 32'h0);
        display_port_a = 1'b1;
        wr(`PLC_PLL_A_CONTROL, 4'h8, 32'h45000000);
        vb(1'b0);
        cyc(2);
        chk("hsio_on", 32'(hsio_a), 32'h1);
        chk("p_dp", 32'(p_a), 32'h0);
        chk("cerr_dp", 32'(cerr_a), 32'h1);
    endtask

    task automatic complete_run;
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #20000;
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clock);
        #1;
        srst = 1'b0;
        t_reset();
        t_protect();
        t_buffer();
        t_ref();
        t_p2();
        t_commit();
        complete_run();
    end
endmodule // tb

`default_nettype wire
